//--- rtl/unary_ops_pkg.sv
// Operation
// - complement inverts file register, routes by destination, updates zero
// - clear-file writes 00h to file, sets zero, never writes working register
// - decrement subtracts one, routes by destination bit, updates zero
// - clear-working loads 00h into working register and sets zero
// - decrement-skip routes; zero squashes next; two cycles; flags kept
// - increment-skip routes; zero squashes next; two cycles; flags kept
// - jump loads 11-bit immediate into program counter bits 10..0
// - jump loads counter bits 14..11 from page latch bits 6..3
// - jump always takes two cycles, discarding the fetched instruction
// - increment adds one, routes by destination bit, updates zero
`default_nettype none
package unary_ops_pkg;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 7;
    localparam int PC_W     = 15;
    localparam int IMM_W    = 11;
    localparam int PAGE_LO  = 3;
    localparam int PAGE_HI  = 6;
    localparam int REGS     = 128;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] W_RESET   = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET  = 15'h0000;

    typedef enum logic [7:0] {
        OP_NONE  = 8'h00,
        OP_COMPL = 8'h01,
        OP_CLR_FILE = 8'h02,
        OP_DEC   = 8'h03,
        OP_CLR_WORK = 8'h04,
        OP_DECSK = 8'h05,
        OP_INCSK = 8'h06,
        OP_JUMP  = 8'h07,
        OP_INC   = 8'h08
    } op_t;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } state_t;

    typedef struct packed {
        op_t                op;
        logic               dest;
        logic [ADDR_W-1:0]  addr;
        logic [IMM_W-1:0]   imm;
    } instr_t;
endpackage : unary_ops_pkg
`default_nettype wire

//--- rtl/file_reg_mem.sv
`default_nettype none
module file_reg_mem #(
    parameter int DW    = 8,
    parameter int AW    = 7,
    parameter int DEPTH = 128
) (
    input  wire logic          clk,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : file_reg_mem
`default_nettype wire

//--- rtl/file_reg_unary_skip_jump_ops.sv
`default_nettype none
module file_reg_unary_skip_jump_ops
    import unary_ops_pkg::*;
(
    input  wire logic                           CORE_CLK,
    input  wire logic                           SRST,
    input  wire unary_ops_pkg::instr_t          INSTR,
    input  wire logic                           INSTR_VALID,
    output logic                                INSTR_READY,
    input  wire logic [7:0]                     PAGE_LATCH,
    output logic [unary_ops_pkg::DATA_W-1:0]    WORK_REG,
    output logic                                ZERO_FLAG,
    output logic [unary_ops_pkg::PC_W-1:0]      PROG_COUNTER,
    output logic                                SQUASH,
    output logic                                DONE
);
    import unary_ops_pkg::*;

    // ------------------------------------------------------------
    // operand fetch
    // ------------------------------------------------------------
    // three cycles per op: latch, read, then execute; keeps the memory read
    // registered at the cost of throughput
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_READ = 3'b010,
        PH_EXE  = 3'b100
    } phase_t;

    phase_t            phase;
    instr_t            cur;
    state_t            state;
    logic [DATA_W-1:0] fdata;
    logic [DATA_W-1:0] result;
    logic              wr_file;
    logic              wr_work;
    logic              upd_zero;
    logic              skip_op;

    file_reg_mem #(
        .DW    (DATA_W),
        .AW    (ADDR_W),
        .DEPTH (REGS)
    ) u_mem (
        .clk   (CORE_CLK),
        .raddr (cur.addr),
        .rdata (fdata),
        .we    (wr_file && phase == PH_EXE),
        .waddr (cur.addr),
        .wdata (result)
    );

    assign INSTR_READY = (phase == PH_IDLE) && (state == ST_EXEC);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            phase <= PH_IDLE;
            cur   <= '0;
        end else begin
            case (phase)
                PH_IDLE: begin
                    if (INSTR_VALID && INSTR_READY) begin
                        cur   <= INSTR;
                        phase <= PH_READ;
                    end
                end
                PH_READ: phase <= PH_EXE;
                PH_EXE:  phase <= PH_IDLE;
                default: phase <= PH_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------
    always_comb begin
        result   = fdata;
        wr_file  = 1'b0;
        wr_work  = 1'b0;
        upd_zero = 1'b0;
        skip_op  = 1'b0;
        case (cur.op)
            OP_COMPL: begin
                result   = ~fdata;
                upd_zero = 1'b1;
            end
            OP_CLR_FILE: begin
                result   = ZERO_BYTE;
                upd_zero = 1'b1;
            end
            OP_DEC: begin
                result   = fdata - 8'h01;
                upd_zero = 1'b1;
            end
            OP_INC: begin
                result   = fdata + 8'h01;
                upd_zero = 1'b1;
            end
            OP_CLR_WORK: begin
                result   = ZERO_BYTE;
                upd_zero = 1'b1;
            end
            OP_DECSK: begin
                result  = fdata - 8'h01;
                skip_op = (result == ZERO_BYTE);
            end
            OP_INCSK: begin
                result  = fdata + 8'h01;
                skip_op = (result == ZERO_BYTE);
            end
            default: result = fdata;
        endcase
        case (cur.op)
            OP_COMPL, OP_DEC, OP_INC, OP_DECSK, OP_INCSK: begin
                wr_file = cur.dest;
                wr_work = !cur.dest;
            end
            OP_CLR_FILE: wr_file = 1'b1;
            OP_CLR_WORK: wr_work = 1'b1;
            default: begin
                wr_file = 1'b0;
                wr_work = 1'b0;
            end
        endcase
    end

    wire exe = (phase == PH_EXE);

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            WORK_REG <= W_RESET;
        end else if (exe && wr_work) begin
            WORK_REG <= result;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ZERO_FLAG <= 1'b0;
        end else if (exe && upd_zero) begin
            ZERO_FLAG <= (result == ZERO_BYTE);
        end
    end

    // ------------------------------------------------------------
    // program counter and squash
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            PROG_COUNTER <= PC_RESET;
        end else if (exe && cur.op == OP_JUMP) begin
            PROG_COUNTER <= {PAGE_LATCH[PAGE_HI:PAGE_LO],
                             cur.imm};
        end else if (exe) begin
            PROG_COUNTER <= PROG_COUNTER + 15'h0001;
        end
    end

    // squash lasts one slot; no instruction is taken during it
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state  <= ST_EXEC;
            SQUASH <= 1'b0;
            DONE   <= 1'b0;
        end else begin
            DONE   <= exe;
            SQUASH <= 1'b0;
            case (state)
                ST_EXEC: begin
                    if (exe && (skip_op || cur.op == OP_JUMP)) begin
                        state  <= ST_FLUSH;
                        SQUASH <= 1'b1;
                    end
                end
                ST_FLUSH: state <= ST_EXEC;
                default:  state <= ST_EXEC;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_clear_file_zero;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_CLR_FILE |=> ZERO_FLAG && $stable(WORK_REG);
    endproperty
    a_clear_file_zero: assert property (p_clear_file_zero)
        else $error("clear-file did not set zero");

    property p_clear_work;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_CLR_WORK |=> WORK_REG == 8'h00 && ZERO_FLAG;
    endproperty
    a_clear_work: assert property (p_clear_work)
        else $error("clear-working wrong");

    property p_compl_w;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_COMPL && !cur.dest
            |=> WORK_REG == ~$past(fdata);
    endproperty
    a_compl_w: assert property (p_compl_w)
        else $error("complement result wrong");

    property p_dec_w;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_DEC && !cur.dest
            |=> WORK_REG == $past(fdata) - 8'h01;
    endproperty
    a_dec_w: assert property (p_dec_w)
        else $error("decrement result wrong");

    property p_inc_zero;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_INC |=> ZERO_FLAG == ($past(fdata) == 8'hFF);
    endproperty
    a_inc_zero: assert property (p_inc_zero)
        else $error("increment zero flag wrong");

    sequence s_skip_hit;
        exe && (cur.op == OP_DECSK || cur.op == OP_INCSK) && skip_op;
    endsequence
    property p_skip;
        @(posedge CORE_CLK) disable iff (SRST)
        s_skip_hit |=> SQUASH && $stable(ZERO_FLAG) ##1 !SQUASH;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip did not squash one slot");

    property p_jump_pc;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_JUMP |=> PROG_COUNTER ==
            {$past(PAGE_LATCH[PAGE_HI:PAGE_LO]), $past(cur.imm)};
    endproperty
    a_jump_pc: assert property (p_jump_pc)
        else $error("jump target wrong");

    property p_jump_flush;
        @(posedge CORE_CLK) disable iff (SRST)
        exe && cur.op == OP_JUMP |=> SQUASH && !INSTR_READY;
    endproperty
    a_jump_flush: assert property (p_jump_flush)
        else $error("jump did not take two cycles");
endmodule : file_reg_unary_skip_jump_ops
`default_nettype wire

//--- dv/tb_file_reg_unary_skip_jump_ops.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    bad_count++; $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb_file_reg_unary_skip_jump_ops
    import unary_ops_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic              sq;
        logic              z;
        logic [DATA_W-1:0] w;
        logic [PC_W-1:0]   pc;
    } expect_t;

    logic              core_clk;
    logic              srst;
    logic              valid;
    logic              ready;
    logic              zero;
    logic              squash;
    logic              done;
    instr_t            instr;
    logic [7:0]        page;
    logic [DATA_W-1:0] work;
    logic [PC_W-1:0]   pc;
    expect_t           notes[$];
    logic [DATA_W-1:0] fm [REGS];
    logic [DATA_W-1:0] m_w;
    logic              m_z;
    logic [PC_W-1:0]   m_pc;
    logic [15:0]       seed = 16'h5A7D;
    int                bad_count;
    int                samples_checked;
    op_t               ops [8] = '{OP_COMPL, OP_CLR_FILE, OP_DEC,
                                   OP_CLR_WORK, OP_DECSK, OP_INCSK,
                                   OP_JUMP, OP_INC};
    // both ends of the address range plus two interior registers
    logic [ADDR_W-1:0] pool [4] = '{7'h00, 7'h7F, 7'h2A, 7'h55};

    file_reg_unary_skip_jump_ops i_file_reg_unary_skip_jump_ops (
        .CORE_CLK     (core_clk),
        .SRST         (srst),
        .INSTR        (instr),
        .INSTR_VALID  (valid),
        .INSTR_READY  (ready),
        .PAGE_LATCH   (page),
        .WORK_REG     (work),
        .ZERO_FLAG    (zero),
        .PROG_COUNTER (pc),
        .SQUASH       (squash),
        .DONE         (done)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // ------------------------------------------------------------
    // driver: offer one instruction, note the expected result
    // ------------------------------------------------------------
    task automatic issue(input op_t op, input logic d,
                         input logic [ADDR_W-1:0] a,
                         input logic [IMM_W-1:0] k, input logic [7:0] pl);
        expect_t           e;
        logic [DATA_W-1:0] r;
        logic              rdy;
        rdy = 1'b0;
        for (int n = 0; n < 20 && !rdy; n++) begin
            @(negedge core_clk);
            rdy = (ready === 1'b1);
        end
        // the page latch is read at execute, so it may only move once
        // the previous op has left execute
        @(posedge core_clk);
        instr <= '{op, d, a, k};
        valid <= 1'b1;
        page  <= pl;
        rdy = 1'b0;
        for (int n = 0; n < 20 && !rdy; n++) begin
            @(negedge core_clk);
            rdy = (ready === 1'b1);
            @(posedge core_clk);
        end
        valid <= 1'b0;
        if (!rdy) begin
            bad_count++;
        end
        case (op)
            OP_COMPL:         r = ~fm[a];
            OP_DEC, OP_DECSK: r = fm[a] - 8'h01;
            OP_INC, OP_INCSK: r = fm[a] + 8'h01;
            default:          r = ZERO_BYTE;
        endcase
        if (op == OP_CLR_FILE) begin
            fm[a] = ZERO_BYTE;
        end else if (op == OP_CLR_WORK) begin
            m_w = ZERO_BYTE;
        end else if (op != OP_JUMP) begin
            if (d) fm[a] = r;
            else m_w = r;
        end
        if (op inside {OP_COMPL, OP_DEC, OP_INC,
                       OP_CLR_FILE, OP_CLR_WORK}) begin
            m_z = (r == ZERO_BYTE);
        end
        e.sq = (op inside {OP_DECSK, OP_INCSK} && r == ZERO_BYTE)
               || op == OP_JUMP;
        m_pc = (op == OP_JUMP) ? {pl[PAGE_HI:PAGE_LO], k}
                               : m_pc + 15'h0001;
        e.z  = m_z;
        e.w  = m_w;
        e.pc = m_pc;
        notes.push_back(e);
    endtask : issue

    // ------------------------------------------------------------
    // monitor: settled outputs at the falling edge
    // ------------------------------------------------------------
    always @(negedge core_clk) begin
        expect_t e;
        if (done === 1'b1) begin
            if (notes.size() == 0) begin
                bad_count++;
                $display("Error t=%0t got=%h exp=%h", $time, done, 1'b0);
            end else begin
                e = notes.pop_front();
                `CHK(work, e.w)
                `CHK(zero, e.z)
                `CHK(pc, e.pc)
                `CHK(squash, e.sq)
                `CHK(ready, ~e.sq)
            end
        end
    end

    task automatic test_done;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // limit: a few hundred ops of under ten cycles each
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        test_done;
    end

    initial begin
        srst = 1'b1;
        valid = 1'b0;
        instr = '0;
        page = 8'h00;
        bad_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(negedge core_clk);
        `CHK(work, W_RESET)
        `CHK(zero, 1'b0)
        `CHK(pc, PC_RESET)
        m_w = W_RESET;
        m_z = 1'b0;
        m_pc = PC_RESET;
        // file memory has no reset, so clear the pool before using it
        foreach (pool[i]) issue(OP_CLR_FILE, 1'b0, pool[i], 11'h000, 8'h00);
        issue(OP_DEC,   1'b1, 7'h7F, 11'h000, 8'h00);
        issue(OP_INCSK, 1'b0, 7'h7F, 11'h000, 8'h00);
        issue(OP_INCSK, 1'b1, 7'h00, 11'h000, 8'h00);
        issue(OP_DECSK, 1'b1, 7'h00, 11'h000, 8'h00);
        issue(OP_JUMP,  1'b0, 7'h00, 11'h7FF, 8'hFF);
        issue(OP_JUMP,  1'b0, 7'h00, 11'h000, 8'h87);
        repeat (400) begin
            seed = lfsr_next(seed);
            issue(ops[seed[2:0]], seed[3], pool[seed[5:4]],
                  seed[15:5], seed[7:0]);
        end
        for (int n = 0; n < 50 && notes.size() > 0; n++) begin
            @(posedge core_clk);
        end
        // a result that never showed up is a failure, not a quiet pass
        if (notes.size() != 0) begin
            bad_count++;
        end
        test_done;
    end
endmodule : tb_file_reg_unary_skip_jump_ops
`default_nettype wire
